// *** rtl/ivm_pkg.sv ***
// Constants, vector layout and lookup functions for the interrupt vector map block
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package ivm_pkg;
   // ----------------------------------------------------------------------------
   // Line numbering
   // ----------------------------------------------------------------------------
   localparam int IVM_EXT_LINE_COUNT = 11;
   localparam int IVM_LINE_IDX = 12;
   localparam int IVM_PIN_LINES = 8;
   localparam int IVM_LINE_ADC = 8;
   localparam int IVM_LINE_USART = 9;
   localparam int IVM_LINE_I2C = 10;
   localparam int IVM_LINE_WAKE_TMR = 11;
   localparam int IVM_INT_LINES = 3;
   // ----------------------------------------------------------------------------
   // Interrupt positions
   // ----------------------------------------------------------------------------
   localparam int IVM_POSITIONS = 32;
   localparam int IVM_POS_WIN_WDOG = 0;
   localparam int IVM_POS_WAKE_TMR = 2;
   localparam int IVM_POS_FLASH = 3;
   localparam int IVM_POS_CLKRST = 4;
   localparam int IVM_POS_PIN0 = 5;
   localparam int IVM_POS_PIN5 = 10;
   localparam int IVM_POS_TBRK = 11;
   localparam int IVM_POS_ADC = 12;
   localparam int IVM_POS_TUP = 13;
   localparam int IVM_POS_TCC = 14;
   localparam int IVM_POS_GTIM = 15;
   localparam int IVM_POS_BTIM = 17;
   localparam int IVM_POS_PIN6 = 21;
   localparam int IVM_POS_PIN7 = 22;
   localparam int IVM_POS_I2C = 23;
   localparam int IVM_POS_SPI = 25;
   localparam int IVM_POS_USART = 27;
   localparam logic [31:0] IVM_USED_POS = 32'h0AE2_FFFD;
   // ----------------------------------------------------------------------------
   // Exception numbers, vectors and listed levels
   // ----------------------------------------------------------------------------
   localparam logic [5:0] IVM_EXC_RESET = 6'h01;
   localparam logic [5:0] IVM_EXC_NMI = 6'h02;
   localparam logic [5:0] IVM_EXC_HARD = 6'h03;
   localparam logic [5:0] IVM_EXC_SVC = 6'h0B;
   localparam logic [5:0] IVM_EXC_PEND_SVC = 6'h0E;
   localparam logic [5:0] IVM_EXC_SYS_TICK = 6'h0F;
   localparam logic [5:0] IVM_EXC_IRQ_BASE = 6'h10;
   localparam logic [5:0] IVM_IRQ_RANK_OFS = 6'h09;
   localparam logic [31:0] IVM_VEC_RESET = 32'h0000_0004;
   localparam logic [31:0] IVM_VEC_SVC = 32'h0000_002C;
   localparam logic [31:0] IVM_VEC_PEND_SVC = 32'h0000_0038;
   localparam logic [31:0] IVM_VEC_WAKE_TMR = 32'h0000_0048;
   localparam logic [31:0] IVM_VEC_PIN0 = 32'h0000_0054;
   localparam logic [31:0] IVM_VEC_PIN6 = 32'h0000_0094;
   localparam logic [7:0] IVM_RANK_RESET = 8'hFD;
   localparam logic [7:0] IVM_RANK_NMI = 8'hFE;
   localparam logic [7:0] IVM_RANK_HARD = 8'hFF;
   localparam logic [7:0] IVM_RANK_SVC = 8'h03;
   localparam logic [7:0] IVM_RANK_PEND_SVC = 8'h05;
   localparam logic [7:0] IVM_RANK_SYS_TICK = 8'h06;
   // ----------------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------------
   localparam logic [31:0] IVM_RST_IRQ = 32'h0000_0000;
   localparam logic [7:0] IVM_RST_PEND = 8'h00;
   localparam logic [2:0] IVM_RST_CAP = 3'h0;
   localparam logic [31:0] IVM_RST_VEC = 32'h0000_0000;
   localparam logic [7:0] IVM_RST_RANK = 8'h00;

   // Table entries are one word each, so the byte address is four per number
   function automatic logic [31:0] ivm_vec_addr(input logic [5:0] num);
      ivm_vec_addr = {24'h00_0000, num, 2'b00};
   endfunction

   // Listed level, two's complement; reserved numbers read as zero
   function automatic logic [7:0] ivm_rank(input logic [5:0] num);
      logic [7:0] r;
      r = 8'h00;
      if (num == IVM_EXC_RESET) begin
         r = IVM_RANK_RESET;
      end else if (num == IVM_EXC_NMI) begin
         r = IVM_RANK_NMI;
      end else if (num == IVM_EXC_HARD) begin
         r = IVM_RANK_HARD;
      end else if (num == IVM_EXC_SVC) begin
         r = IVM_RANK_SVC;
      end else if (num == IVM_EXC_PEND_SVC) begin
         r = IVM_RANK_PEND_SVC;
      end else if (num == IVM_EXC_SYS_TICK) begin
         r = IVM_RANK_SYS_TICK;
      end else if (num >= IVM_EXC_IRQ_BASE) begin
         r = {2'b00, 6'(num - IVM_IRQ_RANK_OFS)};
      end
      ivm_rank = r;
   endfunction
endpackage

// *** rtl/ivm_sync.sv ***
// Two-stage synchroniser for asynchronous line inputs
`timescale 1ns/1ns
`default_nettype none
module ivm_sync #(
   parameter int W = 1
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_sync_out;

   always_comb begin
      next_meta = async_in;
      next_sync_out = meta;
   end

   // The first stage feeds only the second stage
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         meta <= '0;
         sync_out <= '0;
      end else begin
         meta <= next_meta;
         sync_out <= next_sync_out;
      end
   end
endmodule
`default_nettype wire

// *** rtl/ivm_edge.sv ***
// Rising and falling edge detector on synchronised levels
`timescale 1ns/1ns
`default_nettype none
module ivm_edge #(
   parameter int W = 1
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [W-1:0] level,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);
   logic [W-1:0] prev;
   logic [W-1:0] next_prev;

   always_comb begin
      next_prev = level;
      rise = level & ~prev;
      fall = ~level & prev;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         prev <= '0;
      end else begin
         prev <= next_prev;
      end
   end
endmodule
`default_nettype wire

// *** rtl/ivm_vector_map.sv ***
// Top: external line capture, interrupt position routing and vector lookup
`timescale 1ns/1ns
`default_nettype none
module ivm_vector_map (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] pin_line,
   input wire logic [7:0] rising_edge_select,
   input wire logic [7:0] falling_edge_select,
   input wire logic [7:0] software_trigger,
   input wire logic [7:0] pending_clear,
   input wire logic [7:0] irq_mask,
   input wire logic [7:0] event_mask,
   input wire logic analog_watchdog_event,
   input wire logic usart_rx_wake,
   input wire logic i2c_wake,
   input wire logic auto_wakeup_request,
   input wire logic stop_mode,
   input wire logic window_watchdog_irq,
   input wire logic flash_irq,
   input wire logic clock_reset_ctrl_irq,
   input wire logic adv_timer_brake_irq,
   input wire logic adv_timer_update_irq,
   input wire logic adv_timer_capcomp_irq,
   input wire logic general_timer_irq,
   input wire logic basic_timer_irq,
   input wire logic adc_irq,
   input wire logic i2c_irq,
   input wire logic spi_irq,
   input wire logic usart_irq,
   input wire logic [5:0] vec_query_num,
   output logic [31:0] irq_request,
   output logic [7:0] pending_flag,
   output logic event_request,
   output logic wake_request,
   output logic [31:0] vec_addr_out,
   output logic vec_fixed,
   output logic [7:0] vec_rank
);
   import ivm_pkg::*;

   // ----------------------------------------------------------------------------
   // Line synchronisation and edge detection
   // ----------------------------------------------------------------------------
   logic [IVM_LINE_IDX-1:0] line_async;
   logic [IVM_LINE_IDX-1:0] line_sync;
   logic [IVM_LINE_IDX-1:0] line_rise;
   logic [IVM_LINE_IDX-1:0] line_fall;
   logic [2:0] int_cap;
   logic [31:0] next_irq_request;
   logic [7:0] next_pending_flag;
   logic [2:0] next_int_cap;
   logic next_event_request;
   logic next_wake_request;
   logic [31:0] next_vec_addr_out;
   logic next_vec_fixed;
   logic [7:0] next_vec_rank;
   logic [7:0] edge_hit;
   logic [2:0] int_rise;

   // Pins and internal event sources come from other domains
   assign line_async = {auto_wakeup_request, i2c_wake, usart_rx_wake,
                        analog_watchdog_event, pin_line};

   ivm_sync #(.W(IVM_LINE_IDX)) u_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .async_in(line_async),
      .sync_out(line_sync)
   );

   ivm_edge #(.W(IVM_LINE_IDX)) u_edge (
      .clk_sys(clk_sys),
      .rst(rst),
      .level(line_sync),
      .rise(line_rise),
      .fall(line_fall)
   );

   // ----------------------------------------------------------------------------
   // Pin lines and internal capture
   // ----------------------------------------------------------------------------
   always_comb begin
      edge_hit = (line_rise[7:0] & rising_edge_select)
               | (line_fall[7:0] & falling_edge_select)
               | software_trigger;
      // Set beats clear so an edge in the clearing cycle is kept
      next_pending_flag = (pending_flag & ~pending_clear) | edge_hit;
      // Internal lines: rising edge only, only while stopped, no flags of their own
      int_rise = line_rise[IVM_LINE_I2C:IVM_LINE_ADC];
      next_int_cap = stop_mode ? (int_cap | int_rise) : IVM_RST_CAP;
      next_event_request = (|(edge_hit & event_mask))
                         | (stop_mode & (|int_rise));
      next_wake_request = stop_mode & ((|(next_pending_flag & irq_mask))
                        | (|next_int_cap) | line_sync[IVM_LINE_WAKE_TMR]);
   end

   // ----------------------------------------------------------------------------
   // Position routing
   // ----------------------------------------------------------------------------
   always_comb begin
      next_irq_request = IVM_RST_IRQ;
      next_irq_request[IVM_POS_WIN_WDOG] = window_watchdog_irq;
      next_irq_request[IVM_POS_WAKE_TMR] = line_sync[IVM_LINE_WAKE_TMR];
      next_irq_request[IVM_POS_FLASH] = flash_irq;
      next_irq_request[IVM_POS_CLKRST] = clock_reset_ctrl_irq;
      next_irq_request[IVM_POS_PIN5:IVM_POS_PIN0] = pending_flag[5:0] & irq_mask[5:0];
      next_irq_request[IVM_POS_TBRK] = adv_timer_brake_irq;
      next_irq_request[IVM_POS_ADC] = adc_irq | int_cap[0];
      next_irq_request[IVM_POS_TUP] = adv_timer_update_irq;
      next_irq_request[IVM_POS_TCC] = adv_timer_capcomp_irq;
      next_irq_request[IVM_POS_GTIM] = general_timer_irq;
      next_irq_request[IVM_POS_BTIM] = basic_timer_irq;
      next_irq_request[IVM_POS_PIN6] = pending_flag[6] & irq_mask[6];
      next_irq_request[IVM_POS_PIN7] = pending_flag[7] & irq_mask[7];
      next_irq_request[IVM_POS_I2C] = i2c_irq | int_cap[2];
      next_irq_request[IVM_POS_SPI] = spi_irq;
      next_irq_request[IVM_POS_USART] = usart_irq | int_cap[1];
      // Unassigned positions are forced low even if a slice above is miswired
      next_irq_request = next_irq_request & IVM_USED_POS;
   end

   // ----------------------------------------------------------------------------
   // Vector lookup
   // ----------------------------------------------------------------------------
   always_comb begin
      next_vec_addr_out = ivm_vec_addr(vec_query_num);
      next_vec_rank = ivm_rank(vec_query_num);
      next_vec_fixed = (vec_query_num == IVM_EXC_RESET) || (vec_query_num == IVM_EXC_NMI)
                    || (vec_query_num == IVM_EXC_HARD);
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         irq_request <= IVM_RST_IRQ;
         pending_flag <= IVM_RST_PEND;
         int_cap <= IVM_RST_CAP;
         event_request <= 1'b0;
         wake_request <= 1'b0;
         vec_addr_out <= IVM_RST_VEC;
         vec_fixed <= 1'b0;
         vec_rank <= IVM_RST_RANK;
      end else begin
         irq_request <= next_irq_request;
         pending_flag <= next_pending_flag;
         int_cap <= next_int_cap;
         event_request <= next_event_request;
         wake_request <= next_wake_request;
         vec_addr_out <= next_vec_addr_out;
         vec_fixed <= next_vec_fixed;
         vec_rank <= next_vec_rank;
      end
   end

   // ----------------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_int_rise(int i);
      stop_mode && $rose(line_sync[i]);
   endsequence

   sequence s_pin_edge0;
      ($rose(line_sync[0]) && rising_edge_select[0]) || software_trigger[0];
   endsequence

   property p_pin_pending;
      s_pin_edge0 |=> pending_flag[0] ##1 (irq_request[IVM_POS_PIN0] == $past(irq_mask[0]));
   endproperty
   a_pin_pending: assert property (p_pin_pending) else $error("pin edge not pended");

   property p_adc_wake;
      s_int_rise(IVM_LINE_ADC) |=> ##1 irq_request[IVM_POS_ADC];
   endproperty
   a_adc_wake: assert property (p_adc_wake) else $error("line 8 missed");

   property p_usart_wake;
      s_int_rise(IVM_LINE_USART) |-> ##1 event_request ##1 irq_request[IVM_POS_USART];
   endproperty
   a_usart_wake: assert property (p_usart_wake) else $error("line 9 missed");

   property p_i2c_wake;
      s_int_rise(IVM_LINE_I2C) |=> ##1 (irq_request[IVM_POS_I2C] && wake_request);
   endproperty
   a_i2c_wake: assert property (p_i2c_wake) else $error("line 10 missed");

   property p_wake_tmr_route;
      irq_request[IVM_POS_WAKE_TMR] == $past(line_sync[IVM_LINE_WAKE_TMR]);
   endproperty
   a_wake_tmr_route: assert property (p_wake_tmr_route) else $error("timer wake not at pos 2");

   property p_no_cap_awake;
      !stop_mode |=> (int_cap == IVM_RST_CAP);
   endproperty
   a_no_cap_awake: assert property (p_no_cap_awake) else $error("capture outside stop");

   property p_pin3_route;
      (pending_flag[3] && irq_mask[3]) |=> irq_request[IVM_POS_PIN0 + 3];
   endproperty
   a_pin3_route: assert property (p_pin3_route) else $error("pin 3 misrouted");

   property p_pin6_route;
      (pending_flag[6] && irq_mask[6]) |=> irq_request[IVM_POS_PIN6];
   endproperty
   a_pin6_route: assert property (p_pin6_route) else $error("pin 6 misrouted");

   property p_unused;
      (irq_request & ~IVM_USED_POS) == 32'h0000_0000;
   endproperty
   a_unused: assert property (p_unused) else $error("unassigned position asserted");

   property p_level_hold;
      (adc_irq && !int_cap[0]) [*2] ##1 (!adc_irq && !int_cap[0]) |=> !irq_request[IVM_POS_ADC];
   endproperty
   a_level_hold: assert property (p_level_hold) else $error("adc not level");

   property p_timer_group;
      adv_timer_update_irq && adv_timer_brake_irq |=>
         irq_request[IVM_POS_TUP] && irq_request[IVM_POS_TBRK];
   endproperty
   a_timer_group: assert property (p_timer_group) else $error("timer misrouted");

   property p_vec_svc;
      vec_query_num == IVM_EXC_SVC |=> vec_addr_out == IVM_VEC_SVC && vec_rank == IVM_RANK_SVC;
   endproperty
   a_vec_svc: assert property (p_vec_svc) else $error("svc vector wrong");

   property p_vec_pend_svc;
      vec_query_num == IVM_EXC_PEND_SVC |=>
         vec_addr_out == IVM_VEC_PEND_SVC && vec_rank == IVM_RANK_PEND_SVC;
   endproperty
   a_vec_pend_svc: assert property (p_vec_pend_svc) else $error("pend service vector wrong");

   property p_vec_reset;
      vec_query_num == IVM_EXC_RESET |=>
         vec_addr_out == IVM_VEC_RESET && vec_fixed && vec_rank == IVM_RANK_RESET;
   endproperty
   a_vec_reset: assert property (p_vec_reset) else $error("reset vector wrong");

   // Only the three top entries are fixed; everything above hard fault is configurable
   property p_vec_not_fixed;
      vec_query_num > IVM_EXC_HARD |=> !vec_fixed;
   endproperty
   a_vec_not_fixed: assert property (p_vec_not_fixed) else $error("entry wrongly fixed");

   property p_pin_fall;
      (line_fall[3] && falling_edge_select[3]) |=> pending_flag[3];
   endproperty
   a_pin_fall: assert property (p_pin_fall) else $error("falling edge not pended");

   property p_set_wins;
      (software_trigger[0] && pending_clear[0]) |=> pending_flag[0];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear beat a set");

   property p_pend_clear;
      (pending_clear[1] && !software_trigger[1] && !line_rise[1] && !line_fall[1]) |=>
         !pending_flag[1];
   endproperty
   a_pend_clear: assert property (p_pend_clear) else $error("pending not cleared");

   property p_pin_event;
      (line_rise[2] && rising_edge_select[2] && event_mask[2]) |=> event_request;
   endproperty
   a_pin_event: assert property (p_pin_event) else $error("pin event missed");

   property p_awake_no_wake;
      !stop_mode |=> !wake_request;
   endproperty
   a_awake_no_wake: assert property (p_awake_no_wake) else $error("wake outside stop");

   // Internal lines may only pulse the event output while stopped
   property p_awake_no_event;
      (!stop_mode && ((edge_hit & event_mask) == 8'h00)) |=> !event_request;
   endproperty
   a_awake_no_event: assert property (p_awake_no_event) else $error("stray event");

   property p_wdog_route;
      window_watchdog_irq |=> irq_request[IVM_POS_WIN_WDOG];
   endproperty
   a_wdog_route: assert property (p_wdog_route) else $error("watchdog misrouted");

   property p_usart_share;
      usart_irq |=> irq_request[IVM_POS_USART];
   endproperty
   a_usart_share: assert property (p_usart_share) else $error("usart irq misrouted");

   property p_i2c_share;
      i2c_irq |=> irq_request[IVM_POS_I2C];
   endproperty
   a_i2c_share: assert property (p_i2c_share) else $error("i2c irq misrouted");

   property p_capcomp;
      adv_timer_capcomp_irq |=> irq_request[IVM_POS_TCC];
   endproperty
   a_capcomp: assert property (p_capcomp) else $error("capture irq misrouted");

   property p_pin7_route;
      (pending_flag[7] && irq_mask[7]) |=> irq_request[IVM_POS_PIN7];
   endproperty
   a_pin7_route: assert property (p_pin7_route) else $error("pin 7 misrouted");
endmodule
`default_nettype wire

// *** verification/ivm_partner.sv ***
// Far-side model: peripheral flag sources and software mode setup
`timescale 1ns/1ns
`default_nettype none
module ivm_partner (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [11:0] set_flag,
   input wire logic [11:0] clr_flag,
   input wire logic [1:0] cfg_mode,
   input wire logic [2:0] cfg_line,
   output logic [11:0] flags,
   output logic [7:0] irq_mask,
   output logic [7:0] event_mask
);
   logic [11:0] next_flags;
   logic [7:0] next_irq_mask;
   logic [7:0] next_event_mask;
   // A flag stays up until its owner clears it; a set in the same cycle wins
   always_comb begin
      next_flags = (flags & ~clr_flag) | set_flag;
      next_irq_mask = (cfg_mode == 2'h1) ? (8'h01 << cfg_line) : 8'h00;
      next_event_mask = (cfg_mode == 2'h2) ? (8'h01 << cfg_line) : 8'h00;
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         flags <= 12'h000;
         irq_mask <= 8'h00;
         event_mask <= 8'h00;
      end else begin
         flags <= next_flags;
         irq_mask <= next_irq_mask;
         event_mask <= next_event_mask;
      end
   end
endmodule
`default_nettype wire

// *** verification/ivm_vector_map_tb_top.sv ***
// Self-checking bench for the interrupt vector map block
`timescale 1ns/1ns
`default_nettype none
module ivm_vector_map_tb_top;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [7:0] pin_line = 8'h00, rising_edge_select = 8'h00, falling_edge_select = 8'h00;
   logic [7:0] software_trigger = 8'h00, pending_clear = 8'h00;
   logic [2:0] int_src = 3'h0;
   logic auto_wakeup_request = 1'b0, stop_mode = 1'b0;
   logic [11:0] set_flag = 12'h000, clr_flag = 12'h000, flags;
   logic [1:0] cfg_mode = 2'h0;
   logic [2:0] cfg_line = 3'h0;
   logic [5:0] vec_query_num = 6'h00;
   logic [7:0] irq_mask, event_mask, pending_flag, vec_rank;
   logic [31:0] irq_request, vec_addr_out;
   logic event_request, wake_request, vec_fixed;
   typedef struct {int k; logic [31:0] v;} ivm_note_t;
   ivm_note_t q[$];
   int err_count = 0, cmp_count = 0, ev_cnt = 0, exp_ev = 0;
   int pos_of[12] = '{0, 3, 4, 11, 13, 14, 15, 17, 12, 23, 25, 27};

   ivm_partner i_ivm_partner (.clk_sys(clk_sys), .rst(rst), .set_flag(set_flag),
      .clr_flag(clr_flag), .cfg_mode(cfg_mode), .cfg_line(cfg_line), .flags(flags),
      .irq_mask(irq_mask), .event_mask(event_mask));
   ivm_vector_map i_ivm_vector_map (.clk_sys(clk_sys), .rst(rst), .pin_line(pin_line),
      .rising_edge_select(rising_edge_select), .falling_edge_select(falling_edge_select),
      .software_trigger(software_trigger), .pending_clear(pending_clear),
      .irq_mask(irq_mask), .event_mask(event_mask), .analog_watchdog_event(int_src[0]),
      .usart_rx_wake(int_src[1]), .i2c_wake(int_src[2]),
      .auto_wakeup_request(auto_wakeup_request), .stop_mode(stop_mode),
      .window_watchdog_irq(flags[0]), .flash_irq(flags[1]), .clock_reset_ctrl_irq(flags[2]),
      .adv_timer_brake_irq(flags[3]), .adv_timer_update_irq(flags[4]),
      .adv_timer_capcomp_irq(flags[5]), .general_timer_irq(flags[6]),
      .basic_timer_irq(flags[7]), .adc_irq(flags[8]), .i2c_irq(flags[9]), .spi_irq(flags[10]),
      .usart_irq(flags[11]), .vec_query_num(vec_query_num), .irq_request(irq_request),
      .pending_flag(pending_flag), .event_request(event_request),
      .wake_request(wake_request), .vec_addr_out(vec_addr_out), .vec_fixed(vec_fixed),
      .vec_rank(vec_rank));

   // ----------------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------------
   task automatic chk_level(input logic [31:0] got, input logic [31:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask
   task automatic note(input int k, input logic [31:0] v);
      q.push_back('{k, v});
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // Settled outputs after a stimulus; the event count is cumulative
   task automatic state(input logic [31:0] irq, input logic [7:0] pend, input logic wake);
      note(0, irq);
      note(1, {24'h00_0000, pend});
      note(2, 32'(exp_ev));
      note(3, {31'h0000_0000, wake});
   endtask
   function automatic logic [7:0] exp_rank(input int n);
      return (n >= 1 && n <= 3) ? 8'(n - 4) : (n == 11) ? 8'h03 : (n >= 14) ? 8'(n - 9) : 8'h00;
   endfunction
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------------------
   // Clock, monitor and watchdog
   // ----------------------------------------------------------------------------
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end
   // Sampling at the falling edge keeps the compare clear of the launch edge
   always @(negedge clk_sys) begin : mon
      ivm_note_t n;
      if (!rst && event_request === 1'b1) begin
         ev_cnt++;
      end
      while (q.size() > 0) begin
         n = q.pop_front();
         case (n.k)
            0: chk_level(irq_request, n.v, "irq_request");
            1: chk_level({24'h00_0000, pending_flag}, n.v, "pending_flag");
            2: chk_level(32'(ev_cnt), n.v, "event count");
            3: chk_flag(wake_request, n.v[0], "wake_request");
            4: chk_level(vec_addr_out, n.v, "vec_addr_out");
            5: chk_flag(vec_fixed, n.v[0], "vec_fixed");
            default: chk_level({24'h00_0000, vec_rank}, n.v, "vec_rank");
         endcase
      end
   end
   initial begin
      repeat (2000) @(posedge clk_sys);
      err_count++;
      $display("BAD t=%0t watchdog expired", $time);
      conclude();
   end

   // ----------------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------------
   initial begin
      logic [11:0] pat;
      logic [31:0] exp_irq;
      void'($urandom(32'hb389));
      tick(6);
      rst <= 1'b0;
      tick(4);
      state(32'h0000_0000, 8'h00, 1'b0);
      for (int n = 0; n < 64; n++) begin
         vec_query_num <= 6'(n);
         tick(2);
         note(4, 32'(n * 4));
         note(5, {31'h0000_0000, (n >= 1 && n <= 3)});
         note(6, {24'h00_0000, exp_rank(n)});
      end
      for (int r = 0; r < 9; r++) begin
         pat = (r == 0) ? 12'hFFF : 12'($urandom());
         exp_irq = 32'h0000_0000;
         for (int b = 0; b < 12; b++) begin
            exp_irq[pos_of[b]] = pat[b];
         end
         set_flag <= pat;
         tick(1);
         set_flag <= 12'h000;
         tick(4);
         state(exp_irq, 8'h00, 1'b0);
         clr_flag <= 12'hFFF;
         tick(1);
         clr_flag <= 12'h000;
         tick(4);
         state(32'h0000_0000, 8'h00, 1'b0);
      end
      rising_edge_select <= 8'hFF;
      for (int k = 0; k < 8; k++) begin
         cfg_mode <= 2'h1;
         cfg_line <= 3'(k);
         pin_line[k] <= 1'b1;
         tick(8);
         exp_irq = 32'h0000_0000;
         exp_irq[(k < 6) ? 5 + k : 15 + k] = 1'b1;
         state(exp_irq, 8'h01 << k, 1'b0);
         pin_line[k] <= 1'b0;
         tick(8);
         state(exp_irq, 8'h01 << k, 1'b0);
         pending_clear[k] <= 1'b1;
         tick(1);
         pending_clear[k] <= 1'b0;
         tick(4);
         state(32'h0000_0000, 8'h00, 1'b0);
      end
      rising_edge_select <= 8'h00;
      falling_edge_select <= 8'h08;
      cfg_mode <= 2'h2;
      cfg_line <= 3'h3;
      pin_line[3] <= 1'b1;
      tick(8);
      state(32'h0000_0000, 8'h00, 1'b0);
      pin_line[3] <= 1'b0;
      exp_ev++;
      tick(8);
      state(32'h0000_0000, 8'h08, 1'b0);
      cfg_mode <= 2'h1;
      cfg_line <= 3'h7;
      software_trigger[7] <= 1'b1;
      tick(1);
      software_trigger[7] <= 1'b0;
      tick(4);
      state(32'h0040_0000, 8'h88, 1'b0);
      pending_clear <= 8'h88;
      tick(1);
      pending_clear <= 8'h00;
      tick(4);
      state(32'h0000_0000, 8'h00, 1'b0);
      for (int i = 0; i < 3; i++) begin
         stop_mode <= 1'b1;
         int_src[i] <= 1'b1;
         exp_ev++;
         tick(8);
         exp_irq = 32'h0000_0001 << ((i == 0) ? 12 : (i == 1) ? 27 : 23);
         state(exp_irq, 8'h00, 1'b1);
         int_src[i] <= 1'b0;
         tick(8);
         state(exp_irq, 8'h00, 1'b1);
         stop_mode <= 1'b0;
         tick(4);
         state(32'h0000_0000, 8'h00, 1'b0);
         int_src[i] <= 1'b1;
         tick(8);
         state(32'h0000_0000, 8'h00, 1'b0);
         int_src[i] <= 1'b0;
         tick(4);
      end
      stop_mode <= 1'b1;
      auto_wakeup_request <= 1'b1;
      tick(6);
      state(32'h0000_0004, 8'h00, 1'b1);
      auto_wakeup_request <= 1'b0;
      stop_mode <= 1'b0;
      tick(6);
      state(32'h0000_0000, 8'h00, 1'b0);
      tick(2);
      conclude();
   end
endmodule
`default_nettype wire
